// ### core/afrlm_filter.sv
`timescale 1ns/1ps
module afrlm_filter #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic tick,
	input wire logic [7:0] tau_ms,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	import afrlm_pkg::*;
	// First-order IIR; alpha = 1/(10*tau) per 100 us tick, held in a wide accumulator.
	// Each tick moves the accumulator by err/(10*tau), using a signed division of err by div.
	logic [W+11:0] acc_ff;
	logic [W+11:0] nxt_acc;
	logic signed [W+12:0] err;
	logic [11:0] div;
	assign div = (tau_ms == 8'h00) ? 12'h001 : 12'(tau_ms) * 12'h00a;
	assign err = $signed({1'b0, din, 12'h000}) - $signed({1'b0, acc_ff});
	always_comb begin
		nxt_acc = acc_ff;
		if (tau_ms == 8'h00) begin
			nxt_acc = {din, 12'h000};
		end else if (tick) begin
			nxt_acc = (W+12)'($signed({1'b0, acc_ff}) + err / $signed({1'b0, div}));
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_ff <= '0;
		end else begin
			acc_ff <= nxt_acc;
		end
	end
	assign dout = acc_ff[W+11:12];
endmodule

// ### core/afrlm_pkg.sv
package afrlm_pkg;
	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int FILT_TICK_US = 100;
	localparam int FILT_TICK_CYC = (FILT_TICK_US * 1000) / CLK_PERIOD_NS;
	localparam int LOSS_TICK_MS = 1;
	localparam int LOSS_TICK_CYC = (LOSS_TICK_MS * 1000000) / CLK_PERIOD_NS;
	// ------------------------------------------------------------
	// Widths and reset values (levels in 0.01 V or 0.01 mA, freq in 0.01 Hz)
	// ------------------------------------------------------------
	localparam int LVL_W = 16;
	localparam int FRQ_W = 16;
	localparam logic [7:0] FILT_MS_RST = 8'h0a;
	localparam logic [LVL_W-1:0] V_LOW_RST = 16'h0000;
	localparam logic [LVL_W-1:0] V_HIGH_RST = 16'h03e8;
	localparam logic [LVL_W-1:0] I_LOW_RST = 16'h0190;
	localparam logic [LVL_W-1:0] I_HIGH_RST = 16'h07d0;
	localparam logic [FRQ_W-1:0] F_LOW_RST = 16'h0000;
	localparam logic [FRQ_W-1:0] F_HIGH_RST = 16'h1770;
	// ------------------------------------------------------------
	// Enumerations
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		AFRLM_SRC_KEYPAD1 = 3'h0,
		AFRLM_SRC_KEYPAD2 = 3'h1,
		AFRLM_SRC_VOLT = 3'h2,
		AFRLM_SRC_CURR = 3'h3,
		AFRLM_SRC_SUMMED = 3'h4,
		AFRLM_SRC_OTHER = 3'h5
	} afrlm_src_t;
	typedef enum logic [1:0] {
		AFRLM_CRIT_NONE = 2'h0,
		AFRLM_CRIT_HALF = 2'h1,
		AFRLM_CRIT_BELOW = 2'h2
	} afrlm_crit_t;
	typedef enum logic [1:0] {
		AFRLM_REACT_NONE = 2'h0,
		AFRLM_REACT_COAST = 2'h1,
		AFRLM_REACT_STOP = 2'h2
	} afrlm_react_t;
	typedef enum logic [2:0] {
		AFRLM_CODE_NONE = 3'h0,
		AFRLM_CODE_VOLT = 3'h1,
		AFRLM_CODE_CURR = 3'h2,
		AFRLM_CODE_OPTMEM = 3'h3,
		AFRLM_CODE_OPTCOMM = 3'h4,
		AFRLM_CODE_SUBB = 3'h5,
		AFRLM_CODE_KEYPAD = 3'h6
	} afrlm_code_t;
	typedef enum logic [1:0] {
		AFRLM_ST_OK = 2'b00,
		AFRLM_ST_WAIT = 2'b01,
		AFRLM_ST_LOST = 2'b11
	} afrlm_state_t;
	// ------------------------------------------------------------
	// Calibration carrier
	// ------------------------------------------------------------
	typedef struct packed {
		logic [LVL_W-1:0] low_point_level;
		logic [LVL_W-1:0] high_point_level;
		logic [FRQ_W-1:0] low_point_freq;
		logic [FRQ_W-1:0] high_point_freq;
	} afrlm_cal_t;
endpackage

// ### core/afrlm_scale.sv
`timescale 1ns/1ps
module afrlm_scale (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Calibration and level
	input wire afrlm_pkg::afrlm_cal_t cal,
	input wire logic [afrlm_pkg::LVL_W-1:0] lvl,
	// Result
	output logic [afrlm_pkg::FRQ_W-1:0] freq
);
	import afrlm_pkg::*;
	// Registered two-point line with endpoint clamp; one cycle latency.
	logic [FRQ_W-1:0] freq_ff;
	logic [FRQ_W-1:0] nxt_freq;
	logic [LVL_W-1:0] span_l;
	logic [LVL_W-1:0] dl;
	logic signed [FRQ_W+1:0] span_f;
	logic signed [FRQ_W+LVL_W+2:0] prod;
	assign span_l = cal.high_point_level - cal.low_point_level;
	assign dl = lvl - cal.low_point_level;
	assign span_f = $signed({2'b00, cal.high_point_freq}) - $signed({2'b00, cal.low_point_freq});
	assign prod = span_f * $signed({1'b0, dl});
	always_comb begin
		nxt_freq = cal.low_point_freq;
		if (lvl <= cal.low_point_level || span_l == '0) begin
			nxt_freq = cal.low_point_freq;
		end else if (lvl >= cal.high_point_level) begin
			nxt_freq = cal.high_point_freq;
		end else begin
			nxt_freq = FRQ_W'($signed({2'b00, cal.low_point_freq})
				+ prod / $signed({1'b0, span_l}));
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			freq_ff <= '0;
		end else begin
			freq_ff <= nxt_freq;
		end
	end
	assign freq = freq_ff;
endmodule

// ### core/afrlm_top.sv
`timescale 1ns/1ps
module afrlm_top #(
	parameter int LVL_W = 16,
	parameter int TMO_W = 8
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST,
	// Analog samples, 0.01 V and 0.01 mA
	input wire logic [LVL_W-1:0] VOLTAGE_REF_INPUT,
	input wire logic [LVL_W-1:0] CURRENT_REF_INPUT,
	// Source selection and filter settings
	input wire afrlm_pkg::afrlm_src_t FREQ_SOURCE_SELECT,
	input wire logic [7:0] V_FILTER_MS,
	input wire logic [7:0] I_FILTER_MS,
	// Calibration
	input wire afrlm_pkg::afrlm_cal_t V_CAL,
	input wire afrlm_pkg::afrlm_cal_t I_CAL,
	// Loss settings, timeout in 1 ms units
	input wire afrlm_pkg::afrlm_crit_t LOSS_CRITERION,
	input wire afrlm_pkg::afrlm_react_t LOSS_REACTION,
	input wire logic [TMO_W-1:0] LOSS_TIMEOUT_MS,
	// Other loss sources, levels
	input wire logic KEYPAD_CMD_LOST,
	input wire logic OPTION_MEM_TIMEOUT,
	input wire logic OPTION_COMM_FAULT,
	input wire logic SUBBOARD_REF_LOST,
	// Results
	output logic [afrlm_pkg::FRQ_W-1:0] REF_FREQ,
	output logic REF_FREQ_VALID,
	output logic REF_LOST,
	output afrlm_pkg::afrlm_code_t LOSS_CODE,
	output logic COAST_ON_LOSS,
	output logic DECEL_STOP_REQ
);
	import afrlm_pkg::*;

	// ------------------------------------------------------------
	// Tick generators
	// ------------------------------------------------------------
	logic [15:0] ftick_cnt_ff;
	logic [15:0] ltick_cnt_ff;
	wire ftick = (ftick_cnt_ff == 16'(FILT_TICK_CYC - 1));
	wire ltick = (ltick_cnt_ff == 16'(LOSS_TICK_CYC - 1));
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ftick_cnt_ff <= '0;
			ltick_cnt_ff <= '0;
		end else begin
			ftick_cnt_ff <= ftick ? '0 : ftick_cnt_ff + 16'h0001;
			ltick_cnt_ff <= ltick ? '0 : ltick_cnt_ff + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// Filters and scaling
	// ------------------------------------------------------------
	logic [LVL_W-1:0] v_filt;
	logic [LVL_W-1:0] i_filt;
	logic [FRQ_W-1:0] v_freq;
	logic [FRQ_W-1:0] i_freq;
	afrlm_filter #(.W(LVL_W)) u_vfilt (
		.clk(MCLK),
		.rst(RST),
		.tick(ftick),
		.tau_ms(V_FILTER_MS),
		.din(VOLTAGE_REF_INPUT),
		.dout(v_filt)
	);
	afrlm_filter #(.W(LVL_W)) u_ifilt (
		.clk(MCLK),
		.rst(RST),
		.tick(ftick),
		.tau_ms(I_FILTER_MS),
		.din(CURRENT_REF_INPUT),
		.dout(i_filt)
	);
	afrlm_scale u_vscale (
		.clk(MCLK),
		.rst(RST),
		.cal(V_CAL),
		.lvl(v_filt),
		.freq(v_freq)
	);
	afrlm_scale u_iscale (
		.clk(MCLK),
		.rst(RST),
		.cal(I_CAL),
		.lvl(i_filt),
		.freq(i_freq)
	);

	// ------------------------------------------------------------
	// Source selection
	// ------------------------------------------------------------
	wire sel_volt = (FREQ_SOURCE_SELECT == AFRLM_SRC_VOLT);
	wire sel_curr = (FREQ_SOURCE_SELECT == AFRLM_SRC_CURR);
	wire sel_sum = (FREQ_SOURCE_SELECT == AFRLM_SRC_SUMMED);
	wire sel_keypad = (FREQ_SOURCE_SELECT == AFRLM_SRC_KEYPAD1)
		|| (FREQ_SOURCE_SELECT == AFRLM_SRC_KEYPAD2);
	wire use_v = sel_volt || sel_sum;
	wire use_i = sel_curr || sel_sum;
	wire [FRQ_W:0] sum_freq = (use_v ? {1'b0, v_freq} : '0) + (use_i ? {1'b0, i_freq} : '0);
	// Summed mode saturates rather than wrapping at full scale
	wire [FRQ_W-1:0] sel_freq = sum_freq[FRQ_W] ? '1 : sum_freq[FRQ_W-1:0];
	wire analog_sel = use_v || use_i;

	// ------------------------------------------------------------
	// Loss detection
	// ------------------------------------------------------------
	wire [LVL_W-1:0] v_thr = (LOSS_CRITERION == AFRLM_CRIT_HALF) ?
		(V_CAL.low_point_level >> 1) : V_CAL.low_point_level;
	wire [LVL_W-1:0] i_thr = (LOSS_CRITERION == AFRLM_CRIT_HALF) ?
		(I_CAL.low_point_level >> 1) : I_CAL.low_point_level;
	wire crit_on = (LOSS_CRITERION == AFRLM_CRIT_HALF)
		|| (LOSS_CRITERION == AFRLM_CRIT_BELOW);
	wire v_low = crit_on && use_v && (v_filt < v_thr);
	wire i_low = crit_on && use_i && (i_filt < i_thr);
	wire kp_low = sel_keypad && KEYPAD_CMD_LOST;
	wire other_low = OPTION_MEM_TIMEOUT || OPTION_COMM_FAULT || SUBBOARD_REF_LOST;
	wire below = v_low || i_low || kp_low || other_low;
	afrlm_code_t cand_code;
	assign cand_code = v_low ? AFRLM_CODE_VOLT :
		i_low ? AFRLM_CODE_CURR :
		OPTION_MEM_TIMEOUT ? AFRLM_CODE_OPTMEM :
		OPTION_COMM_FAULT ? AFRLM_CODE_OPTCOMM :
		SUBBOARD_REF_LOST ? AFRLM_CODE_SUBB :
		kp_low ? AFRLM_CODE_KEYPAD : AFRLM_CODE_NONE;

	// ------------------------------------------------------------
	// Loss state machine
	// ------------------------------------------------------------
	afrlm_state_t st_ff;
	afrlm_state_t nxt_st;
	logic [TMO_W-1:0] wait_ff;
	logic [TMO_W-1:0] nxt_wait;
	afrlm_code_t code_ff;
	afrlm_code_t nxt_code;
	// The tick runs free, so the first count may come up to 1 ms early:
	// a shorter logic than a restartable per-loss counter, at 1 ms granularity
	wire expired = (wait_ff >= LOSS_TIMEOUT_MS);
	always_comb begin
		nxt_st = st_ff;
		nxt_wait = wait_ff;
		nxt_code = code_ff;
		case (st_ff)
			AFRLM_ST_OK: begin
				nxt_wait = '0;
				if (below) begin
					nxt_st = AFRLM_ST_WAIT;
				end
			end
			AFRLM_ST_WAIT: begin
				if (!below) begin
					nxt_st = AFRLM_ST_OK;
					nxt_wait = '0;
				end else if (expired) begin
					nxt_st = AFRLM_ST_LOST;
					nxt_code = cand_code;
				end else if (ltick) begin
					nxt_wait = wait_ff + 1'b1;
				end
			end
			AFRLM_ST_LOST: begin
				if (!below) begin
					nxt_st = AFRLM_ST_OK;
					nxt_code = AFRLM_CODE_NONE;
				end else begin
					nxt_code = cand_code;
				end
			end
			default: begin
				nxt_st = AFRLM_ST_OK;
			end
		endcase
	end
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			st_ff <= AFRLM_ST_OK;
			wait_ff <= '0;
			code_ff <= AFRLM_CODE_NONE;
		end else begin
			st_ff <= nxt_st;
			wait_ff <= nxt_wait;
			code_ff <= nxt_code;
		end
	end

	// ------------------------------------------------------------
	// Outputs and reaction
	// ------------------------------------------------------------
	logic [FRQ_W-1:0] freq_ff;
	logic valid_ff;
	logic lost_ff;
	afrlm_code_t lcode_ff;
	logic coast_ff;
	logic stop_ff;
	wire lost_now = (st_ff == AFRLM_ST_LOST);
	wire nxt_coast = lost_now && (LOSS_REACTION == AFRLM_REACT_COAST);
	wire nxt_stop = lost_now && (LOSS_REACTION == AFRLM_REACT_STOP);
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			freq_ff <= '0;
			valid_ff <= 1'b0;
			lost_ff <= 1'b0;
			lcode_ff <= AFRLM_CODE_NONE;
			coast_ff <= 1'b0;
			stop_ff <= 1'b0;
		end else begin
			freq_ff <= analog_sel ? sel_freq : '0;
			valid_ff <= analog_sel;
			lost_ff <= lost_now;
			lcode_ff <= code_ff;
			coast_ff <= nxt_coast;
			stop_ff <= nxt_stop;
		end
	end
	assign REF_FREQ = freq_ff;
	assign REF_FREQ_VALID = valid_ff;
	assign REF_LOST = lost_ff;
	assign LOSS_CODE = lcode_ff;
	assign COAST_ON_LOSS = coast_ff;
	assign DECEL_STOP_REQ = stop_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_recovered;
		!below;
	endsequence
	a_crit_off_quiet: assert property (@(posedge MCLK) disable iff (RST)
		(LOSS_CRITERION == AFRLM_CRIT_NONE && !sel_keypad && !other_low) |-> !v_low && !i_low
		&& !below) else $error("loss seen with criterion off");
	a_loss_sel_only: assert property (@(posedge MCLK) disable iff (RST)
		(v_low || i_low) |-> analog_sel) else $error("analog loss outside analog sel");
	a_recover_reset: assert property (@(posedge MCLK) disable iff (RST)
		(st_ff == AFRLM_ST_WAIT) ##0 s_recovered |=> (st_ff == AFRLM_ST_OK) && wait_ff == '0)
		else $error("timer not restarted on recovery");
	a_no_early_lost: assert property (@(posedge MCLK) disable iff (RST)
		(st_ff == AFRLM_ST_WAIT && !expired) |=> st_ff != AFRLM_ST_LOST)
		else $error("loss declared before timeout");
	a_expire_lost: assert property (@(posedge MCLK) disable iff (RST)
		(st_ff == AFRLM_ST_WAIT && expired && below) |=> lost_now)
		else $error("loss not declared at timeout");
	a_coast_react: assert property (@(posedge MCLK) disable iff (RST)
		(lost_now && LOSS_REACTION == AFRLM_REACT_COAST) |=> COAST_ON_LOSS)
		else $error("no coast on loss");
	a_stop_react: assert property (@(posedge MCLK) disable iff (RST)
		(lost_now && LOSS_REACTION == AFRLM_REACT_STOP) |=> DECEL_STOP_REQ && !COAST_ON_LOSS)
		else $error("no decel stop on loss");
	a_none_react: assert property (@(posedge MCLK) disable iff (RST)
		(LOSS_REACTION == AFRLM_REACT_NONE) |=> !COAST_ON_LOSS && !DECEL_STOP_REQ)
		else $error("reaction with setting 0");
	a_volt_code: assert property (@(posedge MCLK) disable iff (RST)
		(st_ff == AFRLM_ST_WAIT && expired && v_low) |=> code_ff == AFRLM_CODE_VOLT)
		else $error("wrong code for voltage loss");
	a_freq_gate: assert property (@(posedge MCLK) disable iff (RST)
		!analog_sel |=> REF_FREQ == '0 && !REF_FREQ_VALID)
		else $error("analog freq outside analog sel");
	a_valid_sel: assert property (@(posedge MCLK) disable iff (RST)
		analog_sel |=> REF_FREQ_VALID && REF_FREQ == $past(sel_freq))
		else $error("selected frequency not passed on");
	sequence s_timed_out;
		(st_ff == AFRLM_ST_WAIT) && expired && below;
	endsequence
	a_curr_code: assert property (@(posedge MCLK) disable iff (RST)
		s_timed_out ##0 (i_low && !v_low) |=> code_ff == AFRLM_CODE_CURR)
		else $error("wrong code for current loss");
	a_keypad_code: assert property (@(posedge MCLK) disable iff (RST)
		s_timed_out ##0 (kp_low && !v_low && !i_low && !other_low)
		|=> code_ff == AFRLM_CODE_KEYPAD)
		else $error("keypad command loss not declared");
	a_half_thr: assert property (@(posedge MCLK) disable iff (RST)
		(LOSS_CRITERION == AFRLM_CRIT_HALF && use_v
		&& v_filt < (V_CAL.low_point_level >> 1)) |-> v_low)
		else $error("half threshold loss missed");
	a_below_thr: assert property (@(posedge MCLK) disable iff (RST)
		(LOSS_CRITERION == AFRLM_CRIT_BELOW && use_v
		&& v_filt < V_CAL.low_point_level) |-> v_low)
		else $error("below threshold loss missed");
	a_wait_hold: assert property (@(posedge MCLK) disable iff (RST)
		(st_ff == AFRLM_ST_WAIT && below && !expired && !ltick) |=> wait_ff == $past(wait_ff))
		else $error("wait timer moved without a tick");
	a_lost_flag: assert property (@(posedge MCLK) disable iff (RST)
		lost_now |=> REF_LOST && LOSS_CODE == $past(code_ff))
		else $error("declared loss not reported");
	a_ok_clear: assert property (@(posedge MCLK) disable iff (RST)
		(st_ff == AFRLM_ST_OK) |=> !REF_LOST && LOSS_CODE == AFRLM_CODE_NONE)
		else $error("loss reported while reference good");
endmodule

// ### verif/afrlm_ref_src.sv
`timescale 1ns/1ps
module afrlm_ref_src (
	// Clock
	input wire logic clk,
	// Commanded source levels
	input wire logic [15:0] v_set,
	input wire logic [15:0] i_set,
	input wire logic wire_open,
	// Levels seen at the terminals
	output logic [15:0] v_out,
	output logic [15:0] i_out
);
	// --------------------------------------------------
	// Source behaviour
	// --------------------------------------------------
	// A broken wire reads 0: the terminals are pulled down inside the drive
	always_ff @(posedge clk) begin
		v_out <= wire_open ? 16'h0000 : v_set;
		i_out <= wire_open ? 16'h0000 : i_set;
	end
endmodule

// ### verif/analog_freq_ref_loss_monitor_tb.sv
`timescale 1ns/1ps
module analog_freq_ref_loss_monitor_tb;
	import afrlm_pkg::*;
	logic mclk, rst, wire_open, kp, om, oc, sb;
	logic [15:0] v_set, i_set, v_in, i_in, ref_freq;
	logic [7:0] vf, ifl, tmo;
	afrlm_src_t src;
	afrlm_crit_t crit;
	afrlm_react_t react;
	afrlm_cal_t v_cal, i_cal;
	logic ref_valid, ref_lost, coast, decel;
	afrlm_code_t loss_code;
	int fail_count = 0;
	int num_checks = 0;
	int edges = 0;
	// --------------------------------------------------
	// Clock, partner and design
	// --------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	afrlm_ref_src SRC (.clk(mclk), .v_set(v_set), .i_set(i_set), .wire_open(wire_open),
		.v_out(v_in), .i_out(i_in));
	afrlm_top DUT (.MCLK(mclk), .RST(rst), .VOLTAGE_REF_INPUT(v_in), .CURRENT_REF_INPUT(i_in),
		.FREQ_SOURCE_SELECT(src), .V_FILTER_MS(vf), .I_FILTER_MS(ifl), .V_CAL(v_cal),
		.I_CAL(i_cal), .LOSS_CRITERION(crit), .LOSS_REACTION(react), .LOSS_TIMEOUT_MS(tmo),
		.KEYPAD_CMD_LOST(kp), .OPTION_MEM_TIMEOUT(om), .OPTION_COMM_FAULT(oc),
		.SUBBOARD_REF_LOST(sb), .REF_FREQ(ref_freq), .REF_FREQ_VALID(ref_valid),
		.REF_LOST(ref_lost), .LOSS_CODE(loss_code), .COAST_ON_LOSS(coast),
		.DECEL_STOP_REQ(decel));
	// --------------------------------------------------
	// Shared tasks
	// --------------------------------------------------
	// Edges since reset release, to place checks against the 1 ms loss tick
	always @(posedge mclk) begin
		edges <= rst ? 0 : edges + 1;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Levels settle within the 3-cycle pipeline plus one partner register
	task automatic apply(input afrlm_src_t s, input logic [15:0] v, input logic [15:0] i);
		@(posedge mclk);
		src <= s;
		v_set <= v;
		i_set <= i;
		cyc(12);
	endtask
	// --------------------------------------------------
	// Scenarios
	// --------------------------------------------------
	task automatic t_filter;
		@(posedge mclk);
		vf <= 8'h0a;
		ifl <= 8'h0a;
		apply(AFRLM_SRC_VOLT, 16'h03e8, 16'h07d0);
		chk("v filter lag", 16'h0001, 16'(ref_freq < 16'h1770));
		apply(AFRLM_SRC_CURR, 16'h03e8, 16'h07d0);
		chk("i filter lag", 16'h0001, 16'(ref_freq < 16'h1770));
		@(posedge mclk);
		vf <= 8'h00;
		ifl <= 8'h00;
	endtask
	task automatic t_scale;
		afrlm_src_t s[8] = '{AFRLM_SRC_VOLT, AFRLM_SRC_VOLT, AFRLM_SRC_VOLT, AFRLM_SRC_VOLT,
			AFRLM_SRC_CURR, AFRLM_SRC_CURR, AFRLM_SRC_SUMMED, AFRLM_SRC_KEYPAD1};
		logic [15:0] v[8] = '{16'h0000, 16'h03e8, 16'h01f4, 16'h04b0, 16'h03e8, 16'h03e8,
			16'h01f4, 16'h01f4};
		logic [15:0] i[8] = '{16'h07d0, 16'h07d0, 16'h07d0, 16'h07d0, 16'h0190, 16'h07d0,
			16'h04b0, 16'h07d0};
		logic [15:0] f[8] = '{16'h0000, 16'h1770, 16'h0bb8, 16'h1770, 16'h0000, 16'h1770,
			16'h1770, 16'h0000};
		for (int k = 0; k < 8; k++) begin
			apply(s[k], v[k], i[k]);
			chk("ref freq", f[k], ref_freq);
			chk("freq valid", 16'(k < 7), 16'(ref_valid));
		end
	endtask
	task automatic loss(input afrlm_src_t s, input afrlm_crit_t c, input afrlm_react_t r,
		input logic [15:0] v, input logic [15:0] i, input logic [3:0] fl, input logic el,
		input afrlm_code_t ec, input logic eco, input logic ede);
		@(posedge mclk);
		crit <= c;
		react <= r;
		{kp, om, oc, sb} <= fl;
		apply(s, v, i);
		chk("lost", 16'(el), 16'(ref_lost));
		chk("code", 16'(ec), 16'(loss_code));
		chk("coast", 16'(eco), 16'(coast));
		chk("decel", 16'(ede), 16'(decel));
		@(posedge mclk);
		{kp, om, oc, sb} <= 4'h0;
		apply(s, 16'h03e8, 16'h07d0);
		chk("lost cleared", 16'h0000, 16'(ref_lost));
	endtask
	// Loss ticks fall every LOSS_TICK_CYC edges after reset; checks sit 200 edges past one,
	// so a timer that is not restarted on recovery reaches 2 ticks before the second check
	task automatic t_timeout;
		@(posedge mclk);
		src <= AFRLM_SRC_VOLT;
		crit <= AFRLM_CRIT_BELOW;
		tmo <= 8'h02;
		wire_open <= 1'b1;
		while (edges < LOSS_TICK_CYC + 200) @(posedge mclk);
		chk("lost after one tick", 16'h0000, 16'(ref_lost));
		wire_open <= 1'b0;
		cyc(20);
		wire_open <= 1'b1;
		while (edges < 2 * LOSS_TICK_CYC + 200) @(posedge mclk);
		chk("lost after restart", 16'h0000, 16'(ref_lost));
		tmo <= 8'h01;
		cyc(6);
		chk("lost at timeout", 16'h0001, 16'(ref_lost));
		chk("timeout code", 16'(AFRLM_CODE_VOLT), 16'(loss_code));
		wire_open <= 1'b0;
		cyc(12);
		chk("lost after recovery", 16'h0000, 16'(ref_lost));
	endtask
	// --------------------------------------------------
	// Main sequence and watchdog
	// --------------------------------------------------
	initial begin
		rst = 1'b1;
		wire_open = 1'b0;
		{kp, om, oc, sb} = 4'h0;
		v_set = 16'h0000;
		i_set = 16'h0190;
		vf = 8'h00;
		ifl = 8'h00;
		tmo = 8'h00;
		src = AFRLM_SRC_VOLT;
		crit = AFRLM_CRIT_NONE;
		react = AFRLM_REACT_NONE;
		v_cal = '{V_LOW_RST, V_HIGH_RST, F_LOW_RST, F_HIGH_RST};
		i_cal = '{I_LOW_RST, I_HIGH_RST, F_LOW_RST, F_HIGH_RST};
		cyc(3);
		rst <= 1'b0;
		t_filter();
		t_scale();
		@(posedge mclk);
		v_cal.low_point_level <= 16'h00c8;
		loss(AFRLM_SRC_VOLT, AFRLM_CRIT_BELOW, AFRLM_REACT_COAST, 16'h0064, 16'h07d0, 4'h0,
			1'b1, AFRLM_CODE_VOLT, 1'b1, 1'b0);
		loss(AFRLM_SRC_VOLT, AFRLM_CRIT_HALF, AFRLM_REACT_STOP, 16'h0096, 16'h07d0, 4'h0,
			1'b0, AFRLM_CODE_NONE, 1'b0, 1'b0);
		loss(AFRLM_SRC_SUMMED, AFRLM_CRIT_HALF, AFRLM_REACT_STOP, 16'h0032, 16'h07d0, 4'h0,
			1'b1, AFRLM_CODE_VOLT, 1'b0, 1'b1);
		loss(AFRLM_SRC_CURR, AFRLM_CRIT_BELOW, AFRLM_REACT_NONE, 16'h03e8, 16'h012c, 4'h0,
			1'b1, AFRLM_CODE_CURR, 1'b0, 1'b0);
		loss(AFRLM_SRC_VOLT, AFRLM_CRIT_NONE, AFRLM_REACT_COAST, 16'h0032, 16'h0000, 4'h0,
			1'b0, AFRLM_CODE_NONE, 1'b0, 1'b0);
		loss(AFRLM_SRC_OTHER, AFRLM_CRIT_BELOW, AFRLM_REACT_COAST, 16'h0032, 16'h0000, 4'h0,
			1'b0, AFRLM_CODE_NONE, 1'b0, 1'b0);
		loss(AFRLM_SRC_KEYPAD1, AFRLM_CRIT_NONE, AFRLM_REACT_COAST, 16'h03e8, 16'h07d0, 4'h8,
			1'b1, AFRLM_CODE_KEYPAD, 1'b1, 1'b0);
		loss(AFRLM_SRC_KEYPAD2, AFRLM_CRIT_NONE, AFRLM_REACT_STOP, 16'h03e8, 16'h07d0, 4'h8,
			1'b1, AFRLM_CODE_KEYPAD, 1'b0, 1'b1);
		loss(AFRLM_SRC_OTHER, AFRLM_CRIT_NONE, AFRLM_REACT_NONE, 16'h03e8, 16'h07d0, 4'h4,
			1'b1, AFRLM_CODE_OPTMEM, 1'b0, 1'b0);
		loss(AFRLM_SRC_OTHER, AFRLM_CRIT_NONE, AFRLM_REACT_NONE, 16'h03e8, 16'h07d0, 4'h2,
			1'b1, AFRLM_CODE_OPTCOMM, 1'b0, 1'b0);
		loss(AFRLM_SRC_OTHER, AFRLM_CRIT_NONE, AFRLM_REACT_NONE, 16'h03e8, 16'h07d0, 4'h1,
			1'b1, AFRLM_CODE_SUBB, 1'b0, 1'b0);
		t_timeout();
		stop_test();
	end
	// The timeout scenario waits through two loss ticks, about 80200 cycles
	initial begin
		repeat (90000) @(posedge mclk);
		fail_count++;
		stop_test();
	end
endmodule
